// >>> dv/flic_core_model.sv
// Core sequencer and peripheral flag owner model facing the controller
`timescale 1ns/1ns
module flic_core_model
  import flic_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Bench commands
  input wire logic [19:0] set_f,
  input wire logic [19:0] clr_f,
  input wire logic ack_en,
  input wire logic ret_cmd,
  // Controller side
  input wire logic irq_req,
  input wire logic [HWCLR_N-1:0] hw_flag_clr,
  output logic [19:0] flag_r,
  output logic call_start,
  output logic handler_return,
  output logic instr_done
);
  // ****************************************
  // Flags and call sequencing
  // ****************************************
  logic [3:0] rcnt_r;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flag_r <= 20'h00000;
      call_start <= 1'b0;
      handler_return <= 1'b0;
      instr_done <= 1'b0;
      rcnt_r <= 4'h0;
    end else begin
      flag_r <= (flag_r & ~clr_f & ~20'(hw_flag_clr)) | set_f;
      call_start <= ack_en & irq_req & ~call_start;
      if (ret_cmd) begin
        rcnt_r <= 4'hd;
      end else if (rcnt_r != 4'h0) begin
        rcnt_r <= rcnt_r - 4'h1;
      end
      handler_return <= (rcnt_r == 4'h9);
      instr_done <= (rcnt_r == 4'h1);
    end
  end
endmodule : flic_core_model

// >>> dv/testbench.sv
// Self-checking bench of the four level interrupt controller
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench
  import flic_pkg::*;
;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic ack_en = 1'b0;
  logic ret_cmd = 1'b0;
  logic [19:0] set_f = 20'h00000;
  logic [19:0] clr_f = 20'h00000;
  logic [19:0] flag_r;
  logic [HWCLR_N-1:0] hw_flag_clr;
  logic call_start, handler_return, instr_done, irq_req;
  logic [15:0] irq_vector;
  logic [1:0] irq_level;
  int failures = 0;
  int checks = 0;
  logic [7:0] m [3];
  logic [7:0] lo [3];
  logic [7:0] hi [3];
  localparam logic [7:0] MA [3] = '{ADDR_MASK_MAIN, ADDR_MASK_A, ADDR_MASK_B};
  localparam logic [7:0] LA [3] = '{ADDR_PLO_MAIN, ADDR_PLO_A, ADDR_PLO_B};
  localparam logic [7:0] HA [3] = '{ADDR_PHI_MAIN, ADDR_PHI_A, ADDR_PHI_B};
  localparam logic [7:0] VM [3] = '{8'hff, 8'hbf, 8'h0f};
  localparam logic [7:0] PM [3] = '{8'h7f, 8'hbf, 8'h0f};

  always #50 ref_clk = ~ref_clk;

  flic_top DUT (.ref_clk(ref_clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .pend_lo(flag_r[4:0]),
    .timer_two_low_overflow(flag_r[5]), .timer_two_high_overflow(flag_r[19]),
    .pend_hi(flag_r[18:6]), .hw_flag_clr(hw_flag_clr), .instr_done(instr_done),
    .call_start(call_start), .handler_return(handler_return), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_level(irq_level));

  flic_core_model partner (.ref_clk(ref_clk), .nrst(nrst), .set_f(set_f), .clr_f(clr_f),
    .ack_en(ack_en), .ret_cmd(ret_cmd), .irq_req(irq_req), .hw_flag_clr(hw_flag_clr),
    .flag_r(flag_r), .call_start(call_start), .handler_return(handler_return),
    .instr_done(instr_done));

  // ****************************************
  // Expectations and bus tasks
  // ****************************************
  function automatic int grp(input int s);
    return (s < 7) ? 0 : (s < 15) ? 1 : 2;
  endfunction : grp

  function automatic int bpos(input int s);
    return s - ((s < 7) ? 0 : (s < 15) ? 7 : 15);
  endfunction : bpos

  function automatic logic [1:0] lvl(input int s);
    return {hi[grp(s)][bpos(s)], lo[grp(s)][bpos(s)]};
  endfunction : lvl

  // Winning source, -1 when none is permitted
  function automatic int winner(input logic [19:0] f);
    int w;
    w = -1;
    for (int s = 0; s < NSRC; s++) begin
      if (s != RESERVED_IDX && m[0][GEN_BIT] && m[grp(s)][bpos(s)] &&
          (f[s] || (s == 5 && f[19])) && (w < 0 || lvl(s) > lvl(w))) begin
        w = s;
      end
    end
    return w;
  endfunction : winner

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    @(negedge ref_clk);
    d = sfr_rdata;
  endtask : rd

  task automatic cfg();
    logic [7:0] d;
    for (int g = 0; g < 3; g++) begin
      wr(MA[g], m[g]);
      wr(LA[g], lo[g]);
      wr(HA[g], hi[g]);
      rd(MA[g], d);
      `CHK(d & VM[g], m[g] & VM[g])
      rd(LA[g], d);
      `CHK(d & PM[g], lo[g] & PM[g])
      rd(HA[g], d);
      `CHK(d & PM[g], hi[g] & PM[g])
    end
  endtask : cfg

  task automatic pulse(input logic [19:0] s, input logic [19:0] c);
    @(posedge ref_clk);
    set_f <= s;
    clr_f <= c;
    @(posedge ref_clk);
    set_f <= 20'h00000;
    clr_f <= 20'h00000;
  endtask : pulse

  task automatic expect_req(input int w);
    @(negedge ref_clk);
    `CHK(irq_req, 1'b0)
    @(negedge ref_clk);
    `CHK(irq_req, 1'(w >= 0))
    if (w >= 0) begin
      `CHK(irq_vector, VEC_BASE + 16'(w * 8))
      `CHK(irq_level, lvl(w))
    end
  endtask : expect_req

  task automatic take(input int w);
    int n;
    expect_req(w);
    if (w >= 0) begin
      n = 0;
      while (call_start !== 1'b1 && n < 5) begin
        @(negedge ref_clk);
        n++;
      end
      repeat (4) begin
        @(negedge ref_clk);
        `CHK(irq_req, 1'b0)
      end
      `CHK(flag_r[w], 1'(w >= HWCLR_N))
      pulse(20'h00000, 20'h1 << w);
    end
  endtask : take

  task automatic ret_chk(input int w);
    int n;
    @(posedge ref_clk);
    ret_cmd <= 1'b1;
    @(posedge ref_clk);
    ret_cmd <= 1'b0;
    n = 0;
    while (instr_done !== 1'b1 && n < 30) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(n < 30, 1'b1)
    take(w);
  endtask : ret_chk

  task automatic end_of_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    end_of_test();
  end

  initial begin
    logic [7:0] d;
    logic [19:0] v;
    void'($urandom(86));
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(ADDR_MASK_MAIN, d);
    `CHK(d, 8'h00)
    `CHK(irq_vector, VEC_RESET)
    rd(ADDR_PLO_MAIN, d);
    `CHK(d, 8'h80)
    rd(ADDR_PHI_MAIN, d);
    `CHK(d, 8'h80)
    rd(8'h00, d);
    `CHK(d, 8'h00)
    $display("test reset done");
    for (int t = 0; t < 24; t++) begin
      for (int g = 0; g < 3; g++) begin
        m[g] = 8'($urandom);
        lo[g] = (t == 0) ? 8'hff : 8'($urandom);
        hi[g] = (t == 0) ? 8'hff : 8'($urandom);
      end
      v = (t == 0) ? 20'hfffff : (t == 1) ? 20'h80000 : 20'($urandom);
      m[0] = (t == 0) ? 8'hff : (t == 1) ? 8'ha0 : m[0];
      cfg();
      pulse(v, 20'h00000);
      expect_req(winner(v));
      pulse(20'h00000, 20'hfffff);
    end
    $display("test arbitration done");
    m = '{8'hff, 8'hff, 8'hff};
    lo = '{8'h07, 8'h02, 8'h00};
    hi = '{8'h03, 8'h00, 8'h02};
    cfg();
    ack_en <= 1'b1;
    pulse(20'h00100, 20'h00000);
    take(8);
    pulse(20'h00004, 20'h00000);
    repeat (6) @(negedge ref_clk);
    `CHK(irq_req, 1'b0)
    pulse(20'h10000, 20'h00000);
    take(16);
    pulse(20'h00001, 20'h00000);
    take(0);
    pulse(20'h00002, 20'h00000);
    repeat (6) @(negedge ref_clk);
    `CHK(irq_req, 1'b0)
    rd(ADDR_ACTIVE, d);
    `CHK(d, 8'h0e)
    ret_chk(1);
    ret_chk(-1);
    ret_chk(-1);
    ret_chk(2);
    ret_chk(-1);
    rd(ADDR_ACTIVE, d);
    `CHK(d, 8'h00)
    $display("test nesting done");
    end_of_test();
  end
endmodule : testbench

// >>> include/flic_cfg_if.sv
// Configuration and nesting state passed between register bank and core
`timescale 1ns/1ns
interface flic_cfg_if;
  logic [18:0] mask;
  logic gen;
  logic [18:0] prio_lo;
  logic [18:0] prio_hi;
  logic [3:0] active;
  modport regs (output mask, gen, prio_lo, prio_hi, input active);
  modport core (input mask, gen, prio_lo, prio_hi, output active);
endinterface : flic_cfg_if

// >>> include/flic_pkg.sv
// Constants, types and decode helpers of the four level interrupt controller
package flic_pkg;

  // ****************************************
  // Sources and register layout
  // ****************************************
  localparam int NSRC = 19;
  localparam logic [7:0] ADDR_MASK_MAIN = 8'ha8;
  localparam logic [7:0] ADDR_PLO_MAIN = 8'hb8;
  localparam logic [7:0] ADDR_PHI_MAIN = 8'h84;
  localparam logic [7:0] ADDR_MASK_A = 8'he6;
  localparam logic [7:0] ADDR_PLO_A = 8'hf6;
  localparam logic [7:0] ADDR_PHI_A = 8'hf5;
  localparam logic [7:0] ADDR_MASK_B = 8'he7;
  localparam logic [7:0] ADDR_PLO_B = 8'hf7;
  localparam logic [7:0] ADDR_PHI_B = 8'hf4;
  localparam logic [7:0] ADDR_ACTIVE = 8'he8;
  localparam int GEN_BIT = 7;
  localparam int MAIN_W = 7;
  localparam int EXT_A_W = 8;
  localparam int EXT_B_W = 4;
  localparam int RESERVED_IDX = 13;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic UNUSED_READ = 1'b1;
  // Sources whose flag is cleared by hardware on vectoring
  localparam int HWCLR_N = 4;

  // ****************************************
  // Vectors and timing
  // ****************************************
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_LAST = 16'h0093;
  localparam int DETECT_CYCLES = 1;
  localparam int CALL_CYCLES = 4;
  localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);

  typedef logic [1:0] flic_lvl_type;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_CALL, ST_HOLD} flic_state_type;

  // Two priority bits to a level, 3 highest
  function automatic flic_lvl_type prio_level(input logic hi, input logic lo);
    return {hi, lo};
  endfunction : prio_level

  // Fixed vector of a source index, eight bytes apart
  function automatic logic [15:0] vec_of(input logic [4:0] idx);
    return VEC_BASE + {8'h00, idx, 3'h0};
  endfunction : vec_of

  // Level of the innermost running handler
  function automatic flic_lvl_type top_active(input logic [3:0] a);
    if (a[3]) return 2'h3;
    if (a[2]) return 2'h2;
    if (a[1]) return 2'h1;
    return 2'h0;
  endfunction : top_active

endpackage : flic_pkg

// >>> verilog/flic_arb.sv
// Combinational priority arbiter over all sources
`timescale 1ns/1ns
module flic_arb
  import flic_pkg::*;
(
  // Clock and reset, assertions only
  input wire logic ref_clk,
  input wire logic nrst,
  // Requests and levels
  input wire logic [NSRC-1:0] req,
  input wire flic_lvl_type lvl [NSRC],
  // Winner
  output logic win_valid,
  output logic [4:0] win_idx,
  output flic_lvl_type win_lvl
);

  logic tie_bad;

  // ****************************************
  // Arbitration
  // ****************************************
  // highest level wins
  always_comb begin
    win_valid = 1'b0;
    win_idx = 5'h00;
    win_lvl = 2'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i] && (!win_valid || lvl[i] >= win_lvl)) begin
        win_valid = 1'b1;
        win_idx = 5'(i);
        win_lvl = lvl[i];
      end
    end
  end

  // Any loser that should have won
  always_comb begin
    tie_bad = 1'b0;
    for (int j = 0; j < NSRC; j++) begin
      if (req[j] && (lvl[j] > win_lvl || (lvl[j] == win_lvl && 5'(j) < win_idx))) begin
        tie_bad = 1'b1;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_winner_order: assert property (win_valid |-> !tie_bad && req[win_idx])
    else $error("arbiter picked a lower ranked source");
  a_decode_every: assert property (win_valid == (|req))
    else $error("pending request not decoded");

endmodule : flic_arb

// >>> verilog/flic_regs.sv
// Mask and priority registers on the special register port
`timescale 1ns/1ns
module flic_regs
  import flic_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Configuration
  flic_cfg_if.regs cfg
);

  logic [7:0] interrupt_mask_main_r, interrupt_mask_main_nxt;
  logic [6:0] priority_low_bits_main_r, priority_low_bits_main_nxt;
  logic [6:0] priority_high_bits_main_r, priority_high_bits_main_nxt;
  logic [7:0] mask_ext_a_r, mask_ext_a_nxt;
  logic [7:0] priority_low_bits_ext_a_r, priority_low_bits_ext_a_nxt;
  logic [7:0] priority_high_bits_ext_a_r, priority_high_bits_ext_a_nxt;
  logic [3:0] mask_ext_b_r, mask_ext_b_nxt;
  logic [3:0] priority_low_bits_ext_b_r, priority_low_bits_ext_b_nxt;
  logic [3:0] priority_high_bits_ext_b_r, priority_high_bits_ext_b_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // ****************************************
  // Writes and reads
  // ****************************************
  always_comb begin
    interrupt_mask_main_nxt = interrupt_mask_main_r;
    priority_low_bits_main_nxt = priority_low_bits_main_r;
    priority_high_bits_main_nxt = priority_high_bits_main_r;
    mask_ext_a_nxt = mask_ext_a_r;
    priority_low_bits_ext_a_nxt = priority_low_bits_ext_a_r;
    priority_high_bits_ext_a_nxt = priority_high_bits_ext_a_r;
    mask_ext_b_nxt = mask_ext_b_r;
    priority_low_bits_ext_b_nxt = priority_low_bits_ext_b_r;
    priority_high_bits_ext_b_nxt = priority_high_bits_ext_b_r;
    rdata_nxt = rdata_r;
    if (sfr_wr) begin
      unique case (sfr_addr)
        ADDR_MASK_MAIN: interrupt_mask_main_nxt = sfr_wdata;
        ADDR_PLO_MAIN: priority_low_bits_main_nxt = sfr_wdata[MAIN_W-1:0];
        ADDR_PHI_MAIN: priority_high_bits_main_nxt = sfr_wdata[MAIN_W-1:0];
        ADDR_MASK_A: mask_ext_a_nxt = sfr_wdata;
        ADDR_PLO_A: priority_low_bits_ext_a_nxt = sfr_wdata;
        ADDR_PHI_A: priority_high_bits_ext_a_nxt = sfr_wdata;
        ADDR_MASK_B: mask_ext_b_nxt = sfr_wdata[EXT_B_W-1:0];
        ADDR_PLO_B: priority_low_bits_ext_b_nxt = sfr_wdata[EXT_B_W-1:0];
        ADDR_PHI_B: priority_high_bits_ext_b_nxt = sfr_wdata[EXT_B_W-1:0];
        default: ;
      endcase
    end
    if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_MASK_MAIN: rdata_nxt = interrupt_mask_main_r;
        ADDR_PLO_MAIN: rdata_nxt = {UNUSED_READ, priority_low_bits_main_r};
        ADDR_PHI_MAIN: rdata_nxt = {UNUSED_READ, priority_high_bits_main_r};
        ADDR_MASK_A: rdata_nxt = mask_ext_a_r;
        ADDR_PLO_A: rdata_nxt = priority_low_bits_ext_a_r;
        ADDR_PHI_A: rdata_nxt = priority_high_bits_ext_a_r;
        ADDR_MASK_B: rdata_nxt = {4'h0, mask_ext_b_r};
        ADDR_PLO_B: rdata_nxt = {4'h0, priority_low_bits_ext_b_r};
        ADDR_PHI_B: rdata_nxt = {4'h0, priority_high_bits_ext_b_r};
        ADDR_ACTIVE: rdata_nxt = {4'h0, cfg.active};
        default: rdata_nxt = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      interrupt_mask_main_r <= REG_RESET;
      priority_low_bits_main_r <= REG_RESET[MAIN_W-1:0];
      priority_high_bits_main_r <= REG_RESET[MAIN_W-1:0];
      mask_ext_a_r <= REG_RESET;
      priority_low_bits_ext_a_r <= REG_RESET;
      priority_high_bits_ext_a_r <= REG_RESET;
      mask_ext_b_r <= REG_RESET[EXT_B_W-1:0];
      priority_low_bits_ext_b_r <= REG_RESET[EXT_B_W-1:0];
      priority_high_bits_ext_b_r <= REG_RESET[EXT_B_W-1:0];
      rdata_r <= REG_RESET;
    end else begin
      interrupt_mask_main_r <= interrupt_mask_main_nxt;
      priority_low_bits_main_r <= priority_low_bits_main_nxt;
      priority_high_bits_main_r <= priority_high_bits_main_nxt;
      mask_ext_a_r <= mask_ext_a_nxt;
      priority_low_bits_ext_a_r <= priority_low_bits_ext_a_nxt;
      priority_high_bits_ext_a_r <= priority_high_bits_ext_a_nxt;
      mask_ext_b_r <= mask_ext_b_nxt;
      priority_low_bits_ext_b_r <= priority_low_bits_ext_b_nxt;
      priority_high_bits_ext_b_r <= priority_high_bits_ext_b_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign cfg.gen = interrupt_mask_main_r[GEN_BIT];
  // Reserved slot never requests
  always_comb begin
    cfg.mask = {mask_ext_b_r, mask_ext_a_r, interrupt_mask_main_r[MAIN_W-1:0]};
    cfg.mask[RESERVED_IDX] = 1'b0;
  end
  assign cfg.prio_lo = {priority_low_bits_ext_b_r, priority_low_bits_ext_a_r,
                        priority_low_bits_main_r};
  assign cfg.prio_hi = {priority_high_bits_ext_b_r, priority_high_bits_ext_a_r,
                        priority_high_bits_main_r};

  default clocking cb @(posedge ref_clk); endclocking

  a_mask_reset: assert property (!nrst |=> interrupt_mask_main_r == 8'h00 && !cfg.gen)
    else $error("main enable register not cleared by reset");

endmodule : flic_regs

// >>> verilog/flic_top.sv
// Four level interrupt controller: gating, arbitration, nesting and call handshake
//
// Operation
// - Every source may be given any of four priority levels independently.
// - A handler is pre-empted only by strictly higher level; level 3 never.
// - Level is high bit and low bit: 00 lowest default, 11 highest.
// - Simultaneous enabled requests: highest configured level is serviced first.
// - Equal levels: smallest fixed index wins, 0 external zero to 18 temperature.
// - Pending requests are sampled and priority decoded every clock cycle.
// - Fastest response five clocks: one to detect, four for the call.
// - Request pending at handler return waits exactly one more instruction.
// - Worst response eighteen clocks: detect, return five, divide eight, call four.
// - Equal or higher running handler holds new requests until return plus one instruction.
// - Leaving a handler, the highest priority pending request is dispatched next.
// - Each source has a fixed vector from 0x0003 in steps of eight; reset 0x0000.
// - Global enable bit 7 blocks all sources when clear, else per mask.
// - Main enable register holds seven source masks in bits 6..0, reset zero.
// - Timer two mask passes either the low or high byte overflow flag.
// - Flags set regardless of enable; a flag still set re-requests after one instruction.
// - External and timer zero/one flags cleared by hardware on vectoring; others by software.
`timescale 1ns/1ns
module flic_top
  import flic_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Pending flags from peripherals
  input wire logic [4:0] pend_lo,
  input wire logic timer_two_low_overflow,
  input wire logic timer_two_high_overflow,
  input wire logic [18:6] pend_hi,
  output logic [HWCLR_N-1:0] hw_flag_clr,
  // Core sequencer
  input wire logic instr_done,
  input wire logic call_start,
  input wire logic handler_return,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [1:0] irq_level
);

  flic_cfg_if cfg ();

  logic [NSRC-1:0] flag_vec;
  logic [NSRC-1:0] req_vec;
  flic_lvl_type lvl [NSRC];
  logic win_valid;
  logic [4:0] win_idx;
  flic_lvl_type win_lvl;
  logic run_valid;
  flic_lvl_type run_lvl;
  logic permit;

  flic_state_type state_r, state_nxt;
  logic [3:0] active_r, active_nxt;
  logic [4:0] idx_r, idx_nxt;
  logic [15:0] vec_r, vec_nxt;
  flic_lvl_type lvl_r, lvl_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [HWCLR_N-1:0] clr_r, clr_nxt;

  // ****************************************
  // Registers
  // ****************************************
  flic_regs u_regs (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata),
    .cfg(cfg.regs)
  );

  // ****************************************
  // Source gating and level decode
  // ****************************************
  // either timer two overflow
  assign flag_vec = {pend_hi, timer_two_high_overflow | timer_two_low_overflow, pend_lo};

  for (genvar g = 0; g < NSRC; g++) begin : g_src
    assign lvl[g] = prio_level(cfg.prio_hi[g], cfg.prio_lo[g]);
    assign req_vec[g] = flag_vec[g] & cfg.mask[g] & cfg.gen;
  end

  // ****************************************
  // Arbitration
  // ****************************************
  // decode every cycle
  flic_arb u_arb (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .req(req_vec),
    .lvl(lvl),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_lvl(win_lvl)
  );

  assign run_valid = |active_r;
  assign run_lvl = top_active(active_r);
  assign permit = win_valid && (!run_valid || win_lvl > run_lvl);

  // ****************************************
  // Dispatch sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    active_nxt = active_r;
    idx_nxt = idx_r;
    vec_nxt = vec_r;
    lvl_nxt = lvl_r;
    cnt_nxt = cnt_r;
    clr_nxt = '0;
    unique case (state_r)
      ST_IDLE: begin
        if (handler_return) begin
          state_nxt = ST_HOLD;
        end else if (permit) begin
          state_nxt = ST_REQ;
          idx_nxt = win_idx;
          vec_nxt = vec_of(win_idx);
          lvl_nxt = win_lvl;
        end
      end
      ST_REQ: begin
        if (call_start) begin
          state_nxt = ST_CALL;
          cnt_nxt = CALL_LAST;
          active_nxt[lvl_r] = 1'b1;
          if (idx_r < 5'(HWCLR_N)) begin
            clr_nxt[idx_r[1:0]] = 1'b1;
          end
        end else if (handler_return) begin
          state_nxt = ST_HOLD;
        end else if (permit) begin
          idx_nxt = win_idx;
          vec_nxt = vec_of(win_idx);
          lvl_nxt = win_lvl;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_CALL: begin
        if (cnt_r == 3'h0) begin
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      ST_HOLD: begin
        if (instr_done) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
    if (handler_return && state_r != ST_CALL) begin
      active_nxt[run_lvl] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      active_r <= 4'h0;
      idx_r <= 5'h00;
      vec_r <= VEC_RESET;
      lvl_r <= 2'h0;
      cnt_r <= 3'h0;
      clr_r <= '0;
    end else begin
      state_r <= state_nxt;
      active_r <= active_nxt;
      idx_r <= idx_nxt;
      vec_r <= vec_nxt;
      lvl_r <= lvl_nxt;
      cnt_r <= cnt_nxt;
      clr_r <= clr_nxt;
    end
  end

  assign cfg.active = active_r;
  assign irq_req = (state_r == ST_REQ);
  assign irq_vector = vec_r;
  assign irq_level = lvl_r;
  assign hw_flag_clr = clr_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_taken;
    irq_req && call_start;
  endsequence

  sequence s_call_quiet;
    (!irq_req) [*4];
  endsequence

  sequence s_call_run;
    (state_r == ST_CALL) [*4] ##1 (state_r == ST_IDLE);
  endsequence

  sequence s_hold_quiet;
    (!irq_req) [*2];
  endsequence

  sequence s_released;
    state_r == ST_HOLD && instr_done ##1 state_r == ST_IDLE;
  endsequence

  a_detect_one: assert property (state_r == ST_IDLE && permit && !handler_return
    |=> irq_req && irq_vector == vec_of($past(win_idx)))
    else $error("request not presented one cycle after detection");
  a_call_quiet: assert property (s_taken |=> s_call_quiet)
    else $error("request presented during the vectored call");
  a_return_hold: assert property (handler_return && state_r != ST_CALL
    |=> s_hold_quiet)
    else $error("request not held after return");
  a_hold_ends: assert property (state_r == ST_HOLD && instr_done |=> state_r == ST_IDLE)
    else $error("hold not released after one instruction");
  a_only_higher: assert property (irq_req && run_valid |-> irq_level > run_lvl)
    else $error("pre-emption by equal or lower level");
  a_top_final: assert property (active_r[3] |-> !irq_req)
    else $error("level three handler pre-empted");
  a_best_level: assert property (irq_req && !$past(call_start)
    |-> irq_level == $past(win_lvl))
    else $error("presented level not the highest pending");
  a_vector_map: assert property (irq_req |-> irq_vector[2:0] == 3'h3
    && irq_vector <= VEC_LAST && irq_vector == vec_of(idx_r))
    else $error("vector outside the fixed table");
  a_global_off: assert property (!cfg.gen |=> !irq_req)
    else $error("request passed with global enable clear");
  a_gate_src: assert property (req_vec[5] |-> cfg.gen && cfg.mask[5]
    && (timer_two_low_overflow || timer_two_high_overflow))
    else $error("timer two request without flag or mask");
  a_gate_all: assert property (win_valid |-> flag_vec[win_idx] && cfg.mask[win_idx])
    else $error("winner without flag or mask");
  a_hw_clear: assert property (s_taken ##0 (idx_r < 5'(HWCLR_N))
    |=> hw_flag_clr != '0 ##1 hw_flag_clr == '0)
    else $error("hardware flag clear not pulsed on vectoring");
  a_sw_clear: assert property (s_taken ##0 (idx_r >= 5'(HWCLR_N)) |=> hw_flag_clr == '0)
    else $error("software cleared flag touched by hardware");
  a_level_map: assert property (lvl[0] == {cfg.prio_hi[0], cfg.prio_lo[0]})
    else $error("level decode wrong");

  // ****************************************
  // Nesting and call checks
  // ****************************************
  a_call_length: assert property (s_taken |=> s_call_run)
    else $error("vectored call not four cycles long");
  a_nest_push: assert property (s_taken |=> active_r[$past(lvl_r)])
    else $error("taken level not marked running");
  a_nest_pop: assert property (handler_return && state_r != ST_CALL && run_valid
    |=> !active_r[$past(run_lvl)])
    else $error("innermost level not released on return");
  a_top_block: assert property (active_r[3] |-> !permit)
    else $error("request permitted over a level three handler");
  a_hold_quiet: assert property (state_r == ST_HOLD && !instr_done |=> !irq_req)
    else $error("request made before the instruction after return");
  a_pend_rerequest: assert property (s_released ##0 (permit && !handler_return)
    |=> irq_req)
    else $error("pending request not raised after the following instruction");
  a_best_next: assert property (s_released ##0 (permit && !handler_return)
    |=> irq_level == $past(win_lvl))
    else $error("next dispatch not the highest pending level");
  a_follow_winner: assert property (state_r == ST_REQ && permit && !call_start
    && !handler_return |=> irq_req && irq_vector == vec_of($past(win_idx)))
    else $error("presented vector does not follow the current winner");
  a_clear_pulse: assert property (hw_flag_clr != '0
    |-> $onehot(hw_flag_clr) && $past(irq_req) && $past(call_start))
    else $error("hardware flag clear without a vectored call");
  a_global_src: assert property (!cfg.gen |-> req_vec == '0)
    else $error("source request passed with global enable clear");
  a_reset_vector: assert property (!$past(nrst)
    |-> irq_vector == VEC_RESET && !irq_req)
    else $error("vector not at reset address after reset");

endmodule : flic_top
